// ---- dsat_defs.vh ----
// Purpose: Constants for the defect sparing address translator.
// Assumes: Included by bare name from the translator and its property file.
// Notes: Definitions only.
`ifndef DSAT_DEFS_VH
`define DSAT_DEFS_VH
`define DSAT_OFS_1K 20'h00033
`define DSAT_OFS_512 20'h0005D
`define DSAT_SPT_1K 20'h00011
`define DSAT_SPT_512 20'h0001F
`define DSAT_SLIP_MAX 12'h800
`define DSAT_MEDIA_650 2'h0
`define DSAT_MEDIA_1G3 2'h1
`define DSAT_MEDIA_2G6 2'h2
`define DSAT_OP_FORMAT 3'h0
`define DSAT_OP_WRITE 3'h1
`define DSAT_OP_ERASE 3'h2
`define DSAT_OP_VERIFY 3'h3
`define DSAT_OP_RREC 3'h4
`define DSAT_OP_READ 3'h5
`define DSAT_ECC_MAX 4'h8
`define DSAT_ECC_FORMAT 4'h3
`define DSAT_ECC_VERIFY 4'h4
`define DSAT_ECC_RREC 4'h7
`define DSAT_ECC_READ 4'h8
`define DSAT_ID_STRICT 2'h2
`define DSAT_ID_LOOSE 2'h1
`define DSAT_ILV_1K 4'hA
`define DSAT_ILV_512 4'h5
`define DSAT_ILB_1K 7'h78
`define DSAT_ILB_512 7'h7A
`endif

// ---- dsat_table_mem.v ----
// Purpose: Small table memory for defect list entries.
// Assumes: One write port, one read port, registered read data.
// Notes: Read data appear one cycle after the address.
`timescale 1ns/100ps
module dsat_table_mem #(
	parameter AW = 11,
	parameter DW = 40
) (
	input wire i_clk, // Clock
	input wire i_we, // Write enable
	input wire [AW-1:0] i_waddr, // Write index
	input wire [DW-1:0] i_wdata, // Write data
	input wire [AW-1:0] i_raddr, // Read index
	output reg [DW-1:0] o_rdata // Registered read data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule

// ---- dsat_translator.v ----
// Purpose: Logical to physical sector translation with slip and replacement sparing.
// Assumes: Inputs synchronous to i_clk; lists loaded before a translation starts.
// Notes: Primary list entries must be sorted ascending by physical block.
`timescale 1ns/100ps
`include "dsat_defs.vh"
// Contract
// - Slip each logical block past earlier primary defects
// - Defect entries and result in track/sector form
// - Add 51 or 93 sector offset
// - Small media: slip, grouping, then replacement
// - Large media: grouping, offset, then replacement
// - Slipping area used only on small media
// - Primary list and grouping written only during format
// - Secondary entry pairs user defect with spare
// - Substitute replacement on secondary list match
// - Reassign appends pair or updates existing entry
// - Update in place only on small media
// - Header good copies counted out of three
// - Correction limit eight bytes per interleave
// - Ten by 120 or five by 122 interleaves
// - Write/erase/verify need two IDs, reads one
// - ECC limits format 3, verify 4, recovered 7, read 8
// - Sparing decisions follow threshold comparison
// - At most 2048 slips; unused slip sectors withheld
module dsat_translator #(
	parameter AW = 11,
	parameter TW = 17,
	parameter SW = 7
) (
	input wire i_clk, // Clock, 125 MHz
	input wire i_rst, // Asynchronous reset, active high
	input wire [1:0] i_media, // Media capacity class
	input wire i_sec512, // Media uses 512-byte sectors
	input wire i_format_mode, // Certification or format in progress
	input wire [19:0] i_grp_n, // Sectors per user group
	input wire [19:0] i_grp_m, // Sectors per spare group
	input wire i_grp_we, // Load grouping parameters
	input wire i_pdl_we, // Append primary list entry
	input wire [TW-1:0] i_pdl_track, // Primary defect track
	input wire [SW-1:0] i_pdl_sector, // Primary defect sector
	input wire i_pdl_clr, // Clear primary list
	input wire i_req, // Translate request pulse
	input wire [19:0] i_lba, // Logical block
	input wire i_realloc, // Reassign request pulse
	input wire [TW-1:0] i_def_track, // Defect track to reassign
	input wire [SW-1:0] i_def_sector, // Defect sector to reassign
	input wire [TW-1:0] i_rep_track, // Replacement track from spare group
	input wire [SW-1:0] i_rep_sector, // Replacement sector from spare group
	input wire i_chk, // Sector result check pulse
	input wire [2:0] i_op, // Operation of the check
	input wire [1:0] i_hdr_good, // Header copies with good CRC, 0..3
	input wire [3:0] i_ecc_max, // Worst corrected bytes in any interleave
	output reg o_valid, // Translation done pulse
	output reg [TW-1:0] o_track, // Resulting track
	output reg [SW-1:0] o_sector, // Resulting sector
	output reg o_busy, // Translation or reassign in progress
	output reg o_refused, // Request refused pulse
	output reg o_chk_ok, // Check result valid pulse
	output reg o_chk_pass, // Sector meets thresholds
	output reg o_spare_req, // Sector should be spared
	output reg [3:0] o_ilv_cnt, // Interleaves per sector
	output reg [6:0] o_ilv_bytes // Bytes per interleave
);
	localparam ST_IDLE = 3'h0;
	localparam ST_GRP1 = 3'h1;
	localparam ST_SLIP = 3'h2;
	localparam ST_GRP2 = 3'h3;
	localparam ST_SDL = 3'h4;
	localparam ST_DONE = 3'h5;
	localparam ST_RSCAN = 3'h6;
	localparam ST_RWR = 3'h7;

	// Linear block from track/sector
	function [19:0] ts2blk;
		input [TW-1:0] t;
		input [SW-1:0] s;
		input sec512;
		begin
			ts2blk = {{(20-TW){1'b0}}, t} * (sec512 ? `DSAT_SPT_512 : `DSAT_SPT_1K)
				+ {{(20-SW){1'b0}}, s};
		end
	endfunction

	// User block to physical block past preceding spare groups
	function [19:0] grp_map;
		input [19:0] b;
		input [19:0] n;
		input [19:0] m;
		begin
			grp_map = (n == 20'h00000) ? b : b + (b / n) * m;
		end
	endfunction

	reg [2:0] state_ff, nxt_state;
	reg [19:0] blk_ff, nxt_blk;
	reg [AW:0] idx_ff, nxt_idx;
	reg [AW:0] pdl_cnt_ff;
	reg [AW:0] sdl_cnt_ff, nxt_sdl_cnt;
	reg [19:0] n_ff, m_ff;
	reg [TW-1:0] ktrk_ff, nxt_ktrk;
	reg [SW-1:0] ksec_ff, nxt_ksec;
	reg [AW:0] hit_ff, nxt_hit;
	reg hit_v_ff, nxt_hit_v;
	reg rd_pend_ff, nxt_rd_pend;
	reg nxt_valid, nxt_refused;
	reg [TW-1:0] nxt_track;
	reg [SW-1:0] nxt_sector;
	reg sdl_we;
	reg [AW-1:0] sdl_waddr;
	wire [TW+SW-1:0] pdl_rdata;
	wire [2*(TW+SW)-1:0] sdl_rdata;
	wire small_media = (i_media == `DSAT_MEDIA_650);
	wire [19:0] ofs = i_sec512 ? `DSAT_OFS_512 : `DSAT_OFS_1K;
	wire [19:0] spt = i_sec512 ? `DSAT_SPT_512 : `DSAT_SPT_1K;
	wire [19:0] cur_trk = blk_ff / spt;
	wire [19:0] cur_sec = blk_ff % spt;
	wire [19:0] pdl_blk = ts2blk(pdl_rdata[TW+SW-1:SW], pdl_rdata[SW-1:0], i_sec512);
	wire [TW-1:0] sdl_dtrk = sdl_rdata[2*(TW+SW)-1:TW+2*SW];
	wire [SW-1:0] sdl_dsec = sdl_rdata[TW+2*SW-1:TW+SW];
	wire pdl_we_ok = i_pdl_we & i_format_mode & (pdl_cnt_ff < `DSAT_SLIP_MAX);
	wire [AW:0] pdl_lim = small_media ? pdl_cnt_ff : {(AW+1){1'b0}};

	dsat_table_mem #(.AW(AW), .DW(TW+SW)) u_pdl (
		.i_clk(i_clk),
		.i_we(pdl_we_ok),
		.i_waddr(pdl_cnt_ff[AW-1:0]),
		.i_wdata({i_pdl_track, i_pdl_sector}),
		.i_raddr(nxt_idx[AW-1:0]),
		.o_rdata(pdl_rdata)
	);

	dsat_table_mem #(.AW(AW), .DW(2*(TW+SW))) u_sdl (
		.i_clk(i_clk),
		.i_we(sdl_we),
		.i_waddr(sdl_waddr),
		.i_wdata({ktrk_ff, ksec_ff, i_rep_track, i_rep_sector}),
		.i_raddr(nxt_idx[AW-1:0]),
		.o_rdata(sdl_rdata)
	);

	always @* begin
		nxt_state = state_ff;
		nxt_blk = blk_ff;
		nxt_idx = idx_ff;
		nxt_ktrk = ktrk_ff;
		nxt_ksec = ksec_ff;
		nxt_hit = hit_ff;
		nxt_hit_v = hit_v_ff;
		nxt_rd_pend = 1'b0;
		nxt_sdl_cnt = sdl_cnt_ff;
		nxt_valid = 1'b0;
		nxt_refused = 1'b0;
		nxt_track = o_track;
		nxt_sector = o_sector;
		sdl_we = 1'b0;
		sdl_waddr = sdl_cnt_ff[AW-1:0];
		case (state_ff)
			ST_IDLE: begin
				nxt_idx = {(AW+1){1'b0}};
				if (i_req) begin
					// Slipped sectors sit after user space; base offset added when the slip scan ends
					nxt_blk = i_lba;
					nxt_rd_pend = 1'b1;
					nxt_state = small_media ? ST_SLIP : ST_GRP1;
				end else if (i_realloc) begin
					nxt_ktrk = i_def_track;
					nxt_ksec = i_def_sector;
					nxt_hit_v = 1'b0;
					nxt_rd_pend = 1'b1;
					nxt_state = ST_RSCAN;
				end
			end
			ST_GRP1: begin
				nxt_blk = grp_map(blk_ff, n_ff, m_ff);
				nxt_rd_pend = 1'b1;
				nxt_state = ST_SLIP;
			end
			ST_SLIP: begin
				// One entry per two cycles; each earlier defect shifts by one
				if (rd_pend_ff) begin
					nxt_rd_pend = 1'b0;
				end else if (idx_ff < pdl_lim && pdl_blk <= blk_ff + ofs) begin
					nxt_blk = blk_ff + 20'h00001;
					nxt_idx = idx_ff + 1'b1;
					nxt_rd_pend = 1'b1;
				end else begin
					nxt_blk = blk_ff + ofs;
					nxt_state = small_media ? ST_GRP2 : ST_SDL;
					nxt_idx = {(AW+1){1'b0}};
					nxt_rd_pend = 1'b1;
				end
			end
			ST_GRP2: begin
				nxt_blk = grp_map(blk_ff - ofs, n_ff, m_ff) + ofs;
				nxt_rd_pend = 1'b1;
				nxt_state = ST_SDL;
			end
			ST_SDL: begin
				// Result moves only with the valid pulse, so it stands between results
				if (rd_pend_ff) begin
					nxt_rd_pend = 1'b0;
				end else if (idx_ff < sdl_cnt_ff) begin
					nxt_idx = idx_ff + 1'b1;
					nxt_rd_pend = 1'b1;
					// Chains on large media are followed by restarting the scan
					if (ts2blk(sdl_dtrk, sdl_dsec, i_sec512) == blk_ff) begin
						nxt_blk = ts2blk(sdl_rdata[TW+SW-1:SW], sdl_rdata[SW-1:0], i_sec512);
						nxt_idx = {(AW+1){1'b0}};
					end
				end else begin
					nxt_track = cur_trk[TW-1:0];
					nxt_sector = cur_sec[SW-1:0];
					nxt_valid = 1'b1;
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			ST_RSCAN: begin
				if (rd_pend_ff) begin
					nxt_rd_pend = 1'b0;
				end else if (idx_ff < sdl_cnt_ff) begin
					if (sdl_dtrk == ktrk_ff && sdl_dsec == ksec_ff) begin
						nxt_hit = idx_ff;
						nxt_hit_v = 1'b1;
					end
					nxt_idx = idx_ff + 1'b1;
					nxt_rd_pend = 1'b1;
				end else begin
					nxt_state = ST_RWR;
				end
			end
			ST_RWR: begin
				if (hit_v_ff && small_media) begin
					sdl_we = 1'b1;
					sdl_waddr = hit_ff[AW-1:0];
				end else if (sdl_cnt_ff < {1'b1, {AW{1'b0}}}) begin
					sdl_we = 1'b1;
					nxt_sdl_cnt = sdl_cnt_ff + 1'b1;
				end else begin
					nxt_refused = 1'b1;
				end
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Threshold check, registered
	reg [1:0] id_need;
	reg [3:0] ecc_lim;
	always @* begin
		id_need = `DSAT_ID_LOOSE;
		ecc_lim = `DSAT_ECC_MAX;
		case (i_op)
			`DSAT_OP_FORMAT: begin
				id_need = `DSAT_ID_STRICT;
				ecc_lim = `DSAT_ECC_FORMAT;
			end
			`DSAT_OP_WRITE, `DSAT_OP_ERASE: begin
				id_need = `DSAT_ID_STRICT;
			end
			`DSAT_OP_VERIFY: begin
				id_need = `DSAT_ID_STRICT;
				ecc_lim = `DSAT_ECC_VERIFY;
			end
			`DSAT_OP_RREC: begin
				ecc_lim = `DSAT_ECC_RREC;
			end
			default: begin
				ecc_lim = `DSAT_ECC_READ;
			end
		endcase
	end
	wire chk_pass = (i_hdr_good >= id_need) && (i_ecc_max <= ecc_lim);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= ST_IDLE;
			blk_ff <= 20'h00000;
			idx_ff <= {(AW+1){1'b0}};
			pdl_cnt_ff <= {(AW+1){1'b0}};
			sdl_cnt_ff <= {(AW+1){1'b0}};
			n_ff <= 20'h00000;
			m_ff <= 20'h00000;
			ktrk_ff <= {TW{1'b0}};
			ksec_ff <= {SW{1'b0}};
			hit_ff <= {(AW+1){1'b0}};
			hit_v_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			o_valid <= 1'b0;
			o_track <= {TW{1'b0}};
			o_sector <= {SW{1'b0}};
			o_busy <= 1'b0;
			o_refused <= 1'b0;
			o_chk_ok <= 1'b0;
			o_chk_pass <= 1'b0;
			o_spare_req <= 1'b0;
			o_ilv_cnt <= `DSAT_ILV_1K;
			o_ilv_bytes <= `DSAT_ILB_1K;
		end else begin
			state_ff <= nxt_state;
			blk_ff <= nxt_blk;
			idx_ff <= nxt_idx;
			ktrk_ff <= nxt_ktrk;
			ksec_ff <= nxt_ksec;
			hit_ff <= nxt_hit;
			hit_v_ff <= nxt_hit_v;
			rd_pend_ff <= nxt_rd_pend;
			sdl_cnt_ff <= nxt_sdl_cnt;
			o_valid <= nxt_valid;
			o_track <= nxt_track;
			o_sector <= nxt_sector;
			o_busy <= (nxt_state != ST_IDLE);
			// Grouping and primary list are frozen outside format
			if (i_format_mode && i_grp_we) begin
				n_ff <= i_grp_n;
				m_ff <= i_grp_m;
			end
			if (i_format_mode && i_pdl_clr && state_ff == ST_IDLE) begin
				pdl_cnt_ff <= {(AW+1){1'b0}};
			end else if (pdl_we_ok) begin
				pdl_cnt_ff <= pdl_cnt_ff + 1'b1;
			end
			o_refused <= nxt_refused | (i_pdl_we & ~pdl_we_ok) | (i_grp_we & ~i_format_mode)
				| ((i_req | i_realloc) & (state_ff != ST_IDLE));
			o_chk_ok <= i_chk;
			o_chk_pass <= i_chk & chk_pass;
			o_spare_req <= i_chk & ~chk_pass & (i_op == `DSAT_OP_FORMAT || i_op == `DSAT_OP_WRITE);
			o_ilv_cnt <= i_sec512 ? `DSAT_ILV_512 : `DSAT_ILV_1K;
			o_ilv_bytes <= i_sec512 ? `DSAT_ILB_512 : `DSAT_ILB_1K;
		end
	end
endmodule

// ---- dsat_translator_props.sv ----
// Purpose: Port properties of the sparing address translator.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Registered outputs answer one edge after their cause.
`timescale 1ns/100ps
`include "dsat_defs.vh"
module dsat_translator_props #(
	parameter TW = 17,
	parameter SW = 7
) (
	input wire i_clk, // Clock
	input wire i_rst, // Reset
	input wire i_sec512, // Small sectors
	input wire i_format_mode, // Format on
	input wire i_pdl_we, // List append
	input wire i_req, // Translate
	input wire i_chk, // Check
	input wire [2:0] i_op, // Check op
	input wire [1:0] i_hdr_good, // Good IDs
	input wire [3:0] i_ecc_max, // Worst ilv
	input wire o_valid, // Result
	input wire [TW-1:0] o_track, // Track
	input wire [SW-1:0] o_sector, // Sector
	input wire o_busy, // Busy
	input wire o_refused, // Refused
	input wire o_chk_ok, // Check done
	input wire o_chk_pass, // Pass
	input wire o_spare_req, // Spare
	input wire [3:0] o_ilv_cnt, // Ilv count
	input wire [6:0] o_ilv_bytes // Ilv bytes
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_take;
		i_req && !o_busy;
	endsequence
	sequence s_small;
		i_sec512 ##1 i_sec512;
	endsequence
	sequence s_big;
		!i_sec512 ##1 !i_sec512;
	endsequence
	a_take_busy: assert property (s_take |=> o_busy)
		else $error("busy not raised");
	a_valid_bound: assert property (s_take |-> ##[2:600] o_valid)
		else $error("no result");
	a_valid_idle: assert property (o_valid |=> !o_busy)
		else $error("busy after result");
	a_result_hold: assert property (!o_valid |-> $stable(o_track) && $stable(o_sector))
		else $error("result moved");
	a_pdl_locked: assert property (i_pdl_we && !i_format_mode |=> o_refused)
		else $error("list write accepted");
	a_chk_answer: assert property (i_chk |=> o_chk_ok)
		else $error("check unanswered");
	a_read_ecc: assert property (i_chk && i_op == `DSAT_OP_READ && i_ecc_max > 4'h8 |=> !o_chk_pass)
		else $error("read over limit passed");
	a_write_ids: assert property (i_chk && i_op == `DSAT_OP_WRITE && i_hdr_good < 2'h2
		|=> !o_chk_pass && o_spare_req)
		else $error("write with one ID passed");
	a_ilv_small: assert property (s_small |=> o_ilv_cnt == 4'h5 && o_ilv_bytes == 7'h7A)
		else $error("small sector layout");
	a_ilv_big: assert property (s_big |=> o_ilv_cnt == 4'hA && o_ilv_bytes == 7'h78)
		else $error("large sector layout");
endmodule

// ---- dsat_chan_model.sv ----
// Purpose: Channel stand-in reporting one sector result per request.
// Assumes: Requests are one-cycle pulses.
// Notes: Fields flip outside report cycles so stale values are never trusted.
`timescale 1ns/100ps
module dsat_chan_model (
	input wire i_clk, // Clock
	input wire i_rst, // Reset
	input wire i_go, // Report
	input wire [2:0] i_op_sel, // Operation
	input wire [1:0] i_hdr, // Good header copies
	input wire [3:0] i_ecc, // Worst interleave
	output wire o_chk, // Result pulse
	output wire [2:0] o_op, // Operation
	output wire [1:0] o_hdr_good, // Good copies of three
	output wire [3:0] o_ecc_max // Worst interleave
);
	logic [9:0] rpt_ff;
	assign {o_chk, o_op, o_hdr_good, o_ecc_max} = rpt_ff;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			rpt_ff <= 10'h000;
		else
			rpt_ff <= i_go ? {1'h1, i_op_sel, i_hdr, i_ecc} : {1'h0, ~rpt_ff[8:0]};
	end
endmodule

// ---- test_defect_sparing_address_translator.sv ----
// Purpose: Self-checking bench for the sparing address translator.
// Assumes: Host side driven here, channel results from the model.
// Notes: Outputs sampled on the falling edge, clear of updates.
`timescale 1ns/100ps
module test_defect_sparing_address_translator;
	logic i_clk = 0, i_rst = 1, i_sec512 = 0, i_format_mode = 0, i_grp_we = 0;
	logic i_pdl_we = 0, i_pdl_clr = 0, i_req = 0, i_realloc = 0, go = 0;
	logic [1:0] i_media = 0, hdr = 0;
	logic [19:0] i_grp_n = 0, i_grp_m = 0, i_lba = 0;
	logic [16:0] i_pdl_track = 0, i_def_track = 0, i_rep_track = 0;
	logic [6:0] i_pdl_sector = 0, i_def_sector = 0, i_rep_sector = 0;
	logic [2:0] op = 0;
	logic [3:0] ecc = 0;
	wire i_chk, o_valid, o_busy, o_refused, o_chk_ok, o_chk_pass, o_spare_req;
	wire [2:0] i_op;
	wire [1:0] i_hdr_good;
	wire [3:0] i_ecc_max, o_ilv_cnt;
	wire [16:0] o_track;
	wire [6:0] o_sector, o_ilv_bytes;
	int err_total = 0, n_checks = 0;
	always #4 i_clk = ~i_clk;
	dsat_translator u_dsat_translator (.i_clk, .i_rst, .i_media, .i_sec512, .i_format_mode,
		.i_grp_n, .i_grp_m, .i_grp_we, .i_pdl_we, .i_pdl_track, .i_pdl_sector, .i_pdl_clr,
		.i_req, .i_lba, .i_realloc, .i_def_track, .i_def_sector, .i_rep_track, .i_rep_sector,
		.i_chk, .i_op, .i_hdr_good, .i_ecc_max, .o_valid, .o_track, .o_sector, .o_busy,
		.o_refused, .o_chk_ok, .o_chk_pass, .o_spare_req, .o_ilv_cnt, .o_ilv_bytes);
	dsat_chan_model u_dsat_chan_model (.i_clk, .i_rst, .i_go(go), .i_op_sel(op), .i_hdr(hdr),
		.i_ecc(ecc), .o_chk(i_chk), .o_op(i_op), .o_hdr_good(i_hdr_good), .o_ecc_max(i_ecc_max));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic translate(input logic [19:0] lba, input logic [16:0] t, input logic [6:0] s);
		@(posedge i_clk);
		i_lba <= lba;
		i_req <= 1'h1;
		@(posedge i_clk);
		i_req <= 1'h0;
		for (int k = 0; k < 500 && o_valid !== 1'h1; k++)
			@(negedge i_clk);
		check({o_valid, o_track, o_sector}, {1'h1, t, s});
	endtask
	task automatic realloc(input logic [16:0] dt, input logic [6:0] ds, input logic [16:0] rt);
		@(posedge i_clk);
		i_def_track <= dt;
		i_def_sector <= ds;
		i_rep_track <= rt;
		i_rep_sector <= 7'h01;
		i_realloc <= 1'h1;
		@(posedge i_clk);
		i_realloc <= 1'h0;
		@(negedge i_clk);
		check(o_busy, 1'h1);
		for (int k = 0; k < 500 && o_busy === 1'h1; k++)
			@(negedge i_clk);
	endtask
	// Defects at physical blocks 71 and 81, groups of 41 user and 2 spare sectors
	task automatic fmt(input logic [1:0] media);
		@(posedge i_clk);
		i_media <= media;
		i_format_mode <= 1'h1;
		i_grp_n <= 20'h00029;
		i_grp_m <= 20'h00002;
		i_grp_we <= 1'h1;
		i_pdl_clr <= 1'h1;
		@(posedge i_clk);
		i_grp_we <= 1'h0;
		i_pdl_clr <= 1'h0;
		i_pdl_we <= 1'h1;
		i_pdl_track <= 17'h00004;
		i_pdl_sector <= 7'h03;
		@(posedge i_clk);
		i_pdl_sector <= 7'h0D;
		@(posedge i_clk);
		i_pdl_we <= 1'h0;
		i_format_mode <= 1'h0;
	endtask
	task automatic t_sec512;
		@(posedge i_clk);
		i_sec512 <= 1'h1;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		check({o_ilv_cnt, o_ilv_bytes}, {4'h5, 7'h7A});
		translate(20'h00028, 17'h00004, 7'h09);
		@(posedge i_clk);
		i_sec512 <= 1'h0;
	endtask
	task automatic t_order;
		fmt(2'h1);
		translate(20'h0002D, 17'h00005, 7'h0D);
		fmt(2'h2);
		translate(20'h0002D, 17'h00005, 7'h0D);
		fmt(2'h0);
		translate(20'h00014, 17'h00004, 7'h04);
		translate(20'h00028, 17'h00005, 7'h0A);
	endtask
	task automatic t_locked;
		@(posedge i_clk);
		i_pdl_we <= 1'h1;
		i_pdl_track <= 17'h00002;
		i_pdl_sector <= 7'h00;
		@(posedge i_clk);
		i_pdl_we <= 1'h0;
		@(negedge i_clk);
		check(o_refused, 1'h1);
		translate(20'h00028, 17'h00005, 7'h0A);
	endtask
	task automatic t_spare;
		realloc(17'h00005, 7'h0A, 17'h000C8);
		translate(20'h00028, 17'h000C8, 7'h01);
		realloc(17'h00005, 7'h0A, 17'h000C9);
		translate(20'h00028, 17'h000C9, 7'h01);
	endtask
	task automatic t_busy;
		@(posedge i_clk);
		i_lba <= 20'h00028;
		i_req <= 1'h1;
		@(posedge i_clk);
		i_req <= 1'h0;
		i_realloc <= 1'h1;
		@(posedge i_clk);
		i_realloc <= 1'h0;
		@(negedge i_clk);
		check({o_busy, o_refused}, 2'h3);
		for (int k = 0; k < 500 && o_valid !== 1'h1; k++)
			@(negedge i_clk);
		check({o_valid, o_track, o_sector}, {1'h1, 17'h000C9, 7'h01});
	endtask
	// Large media: appended pairs leave earlier pointers intact
	task automatic t_chain;
		fmt(2'h1);
		realloc(17'h00005, 7'h06, 17'h000CA);
		translate(20'h00028, 17'h000CA, 7'h01);
		realloc(17'h000CA, 7'h01, 17'h000CB);
		realloc(17'h00005, 7'h06, 17'h000CC);
		translate(20'h00028, 17'h000CB, 7'h01);
	endtask
	task automatic t_full;
		@(posedge i_clk);
		i_format_mode <= 1'h1;
		i_pdl_clr <= 1'h1;
		@(posedge i_clk);
		i_pdl_clr <= 1'h0;
		i_pdl_we <= 1'h1;
		repeat (2048) @(posedge i_clk);
		@(negedge i_clk);
		check(o_refused, 1'h0);
		@(posedge i_clk);
		i_pdl_we <= 1'h0;
		i_format_mode <= 1'h0;
		@(negedge i_clk);
		check(o_refused, 1'h1);
	endtask
	task automatic sector(input logic [2:0] o, input logic [1:0] h, input logic [3:0] e, input logic ok);
		@(posedge i_clk);
		op <= o;
		hdr <= h;
		ecc <= e;
		go <= 1'h1;
		@(posedge i_clk);
		go <= 1'h0;
		@(posedge i_clk);
		@(negedge i_clk);
		check({o_chk_ok, o_chk_pass, o_spare_req}, {1'h1, ok, !ok && o < 3'h2});
	endtask
	task automatic t_thresholds;
		logic [1:0] idmin [6] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
		logic [3:0] lim [6] = '{4'h3, 4'h8, 4'h8, 4'h4, 4'h7, 4'h8};
		for (int i = 0; i < 6; i++) begin
			sector(i[2:0], idmin[i], lim[i], 1'h1);
			sector(i[2:0], idmin[i] - 2'h1, lim[i], 1'h0);
			if (lim[i] != 4'h8 || i == 5)
				sector(i[2:0], 2'h3, lim[i] + 4'h1, 1'h0);
		end
	endtask
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'h0;
		@(negedge i_clk);
		check({o_ilv_cnt, o_ilv_bytes, o_valid}, {4'hA, 7'h78, 1'h0});
		translate(20'h00028, 17'h00005, 7'h06);
		t_sec512();
		t_order();
		t_locked();
		t_spare();
		t_busy();
		t_chain();
		t_thresholds();
		t_full();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		err_total++;
		report_and_stop();
	end
endmodule
bind dsat_translator dsat_translator_props #(.TW(TW), .SW(SW)) u_dsat_translator_props (
	.i_clk, .i_rst, .i_sec512, .i_format_mode, .i_pdl_we, .i_req, .i_chk, .i_op, .i_hdr_good,
	.i_ecc_max, .o_valid, .o_track, .o_sector, .o_busy, .o_refused, .o_chk_ok, .o_chk_pass,
	.o_spare_req, .o_ilv_cnt, .o_ilv_bytes);
